/* bench/tb_timing_logic_function_block.sv */
`include "tlf_consts.vh"
module tb_timing_logic_function_block;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int T = 10;                       // cycles per second
  localparam [31:0] one_v = `TLF_ONE;
  localparam [31:0] t_v = 32'h0000_0001;
  reg         mclk;
  reg         rst_n;
  wire [2:0]  op_sel;
  wire [31:0] in_a, in_b, in_c, out_val;
  reg  [31:0] v;
  int mismatches, tests_run, n, m, i, a, b, c, h, d;
  int wa[5] = '{300, 299, 298, 299, 500};
  reg [31:0] we[5] = '{one_v, one_v, 32'h0000_0000, 32'h0000_0000, one_v};
  tlf_operand_src src (.clk(mclk), .op_sel(op_sel), .in_a(in_a), .in_b(in_b), .in_c(in_c));
  tlf_timing_logic #(.TICK_CYCLES(T)) dut (.MCLK(mclk), .RST_N(rst_n), .OP_SEL(op_sel),
    .IN_A(in_a), .IN_B(in_b), .IN_C(in_c), .OUT_VAL(out_val));
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  task check(input [31:0] seen, input [31:0] exp);
    begin
      tests_run++;
      if (seen !== exp) begin
        mismatches++;
        $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task wt(input int k);
    repeat (k) @(negedge mclk);
  endtask
  task pls(input int up, input int dn);
    begin
      src.put(6, up * $urandom_range(50, 1), dn * $urandom_range(50, 1), 0);
      src.put(6, 0, 0, 0);
    end
  endtask
  function [31:0] rng(input [31:0] x, input int lo, input int hi);
    rng = (int'(x) >= lo && int'(x) <= hi) ? t_v : 32'h0000_0000;
  endfunction
  function [31:0] win_exp(input int a, input int b, input int c);
    int h;
    h = (c < 0 ? -c : c) / 2;
    win_exp = ((a >= b - h && a <= b + h) != (c < 0)) ? one_v : 32'h0000_0000;
  endfunction
  task results;
    begin
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  // watchdog
  initial begin
    #100000;
    mismatches++;
    results;
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    mismatches = 0;
    tests_run = 0;
    rst_n = 1'b0;
    v = $urandom(14155);
    wt(12);
    rst_n = 1'b1;
    wt(1);
    check(out_val, 32'h0000_0000);
    src.put(6, 0, 0, 100);
    wt(3);
    n = $urandom_range(9, 2);
    m = $urandom_range(n - 1, 1);
    repeat (n) pls(1, 0);
    repeat (m) pls(0, 1);
    pls(1, 1);
    wt(2);
    check(out_val, 32'(100 * (n - m)));
    src.put(6, 100, 0, 100);
    wt(2);
    check(out_val, 32'h0000_0000);
    src.put(2, 0, 0, 0);
    wt(3);
    src.put(2, 100, 0, 0);
    wt(3 * T);
    check(rng(out_val, 200, 300), t_v);
    src.put(2, 100, 100, 0);
    wt(2);
    v = out_val;
    wt(3 * T);
    check(out_val, v);
    src.put(2, 100, 0, 0);
    wt(2 * T + 2);
    check(rng(out_val, int'(v) + 100, int'(v) + 300), t_v);
    src.put(2, 0, 0, 0);
    wt(2);
    check(out_val, 32'h0000_0000);
    src.put(0, 0, 250, 0);
    wt(3);
    src.put(0, 100, 250, 0);
    wt(T / 2);
    check(out_val, 32'h0000_0000);
    wt(3 * T);
    check(out_val, one_v);
    src.put(0, 100, 250, 100);
    wt(2);
    check(out_val, 32'h0000_0000);
    src.put(1, 100, 100, 0);
    wt(3);
    src.put(1, 0, 100, 0);
    wt(2);
    check(out_val, one_v);
    wt(3 * T);
    check(out_val, 32'h0000_0000);
    src.put(3, 0, 300, 0);
    wt(3);
    src.put(3, 100, 300, 0);
    src.put(3, 0, 300, 0);
    wt(T);
    check(out_val, one_v);
    wt(4 * T);
    check(out_val, 32'h0000_0000);
    src.put(3, 0, 300, 100);
    wt(2);
    check(out_val, one_v);
    src.put(4, 100, 100, 200);
    n = 0;
    for (i = 0; i < 6 * T; i++) begin
      wt(1);
      n += (out_val != 0);
    end
    check(rng(32'(n), 5, 4 * T), t_v);
    src.put(4, 0, 100, 200);
    wt(3);
    check(out_val, 32'h0000_0000);
    src.put(5, 0, 0, 0);
    wt(3);
    check(out_val, one_v);
    for (i = 0; i < 5; i++) begin
      src.put(5, wa[i], 500, 400);
      wt(1);
      check(out_val, we[i]);
    end
    src.put(5, 500, 500, -400);
    wt(2);
    check(out_val, 32'h0000_0000);
    for (i = 0; i < 40; i++) begin
      a = $urandom_range(3000, 0);
      b = $urandom_range(2000, 0);
      c = $urandom_range(800, 0) * ($urandom_range(1, 0) ? -1 : 1);
      h = (c < 0 ? -c : c) / 2;
      d = a > b ? a - b : b - a;
      if (d + 2 >= h && d <= h + 2) a = b;
      src.put(5, a, b, c);
      wt(2);
      check(out_val, win_exp(a, b, c));
    end
    results;
  end
endmodule

/* bench/tlf_checker_assertions.sv */
`include "tlf_consts.vh"
// ****************************************
// port checker
// ****************************************
module tlf_checker (
  input wire        MCLK,    // clock
  input wire        RST_N,   // reset, low
  input wire [2:0]  OP_SEL,  // mode
  input wire [31:0] IN_A,    // operand a
  input wire [31:0] IN_B,    // operand b
  input wire [31:0] IN_C,    // operand c
  input wire [31:0] OUT_VAL  // result
);
  timeunit 1ns;
  timeprecision 1ps;
  reg  [8:0] op_q;                    // last three modes
  reg        a1_q;                    // a true last cycle
  reg        b1_q;                    // b true last cycle
  wire       stb = ({3{OP_SEL}} == op_q);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  // mode and operand history
  always @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      op_q <= 9'h1FF;
      a1_q <= 1'b0;
      b1_q <= 1'b0;
    end else begin
      op_q <= {op_q[5:0], OP_SEL};
      a1_q <= |IN_A;
      b1_q <= |IN_B;
    end
  end
  rst_zero_a: assert property ($rose(RST_N) |-> OUT_VAL == 32'h0000_0000)
    else $error("output not zero after reset");
  sat_range_a: assert property ($signed(OUT_VAL) <= $signed(`TLF_SAT_MAX)
    && $signed(OUT_VAL) >= $signed(`TLF_SAT_MIN)) else $error("output out of range");
  cnt_up_a: assert property (stb && OP_SEL == 3'h6 && IN_C == 0 && IN_A != 0 && !a1_q
    && !(IN_B != 0 && !b1_q) && $signed(OUT_VAL) < $signed(`TLF_SAT_MAX)
    |=> OUT_VAL == $past(OUT_VAL) + `TLF_ONE) else $error("count did not step up");
  cnt_clr_a: assert property (stb && OP_SEL == 3'h6 && IN_C != 0 |=> OUT_VAL == 0)
    else $error("count not held at zero");
  tmr_clr_a: assert property (stb && OP_SEL == 3'h2 && IN_A == 0 && IN_B == 0
    |=> OUT_VAL == 0) else $error("timer not cleared");
  tmr_hold_a: assert property (stb && OP_SEL == 3'h2 && IN_B != 0 && b1_q
    |=> $stable(OUT_VAL)) else $error("timer not held");
  ond_low_a: assert property (stb && OP_SEL == 3'h0 && IN_A == 0 && IN_C == 0
    |=> OUT_VAL == 0) else $error("on delay output not false");
  win_eq_a: assert property (stb && OP_SEL == 3'h5 && IN_C == 0 && IN_A == IN_B
    |=> OUT_VAL == `TLF_ONE) else $error("equal window not true");
  cnt_up_c: cover property (stb && OP_SEL == 3'h6 && IN_A != 0 && !a1_q);
  tmr_hold_c: cover property (stb && OP_SEL == 3'h2 && IN_B != 0 && b1_q);
  win_eq_c: cover property (stb && OP_SEL == 3'h5 && IN_C == 0 && IN_A == IN_B);
endmodule
bind tlf_timing_logic tlf_checker chk (.MCLK(MCLK), .RST_N(RST_N), .OP_SEL(OP_SEL),
  .IN_A(IN_A), .IN_B(IN_B), .IN_C(IN_C), .OUT_VAL(OUT_VAL));

/* bench/tlf_operand_src.sv */
// ****************************************
// operands from neighbouring blocks
// ****************************************
module tlf_operand_src (
  input  wire        clk,     // bench clock
  output reg  [2:0]  op_sel,  // mode
  output reg  [31:0] in_a,    // operand a
  output reg  [31:0] in_b,    // operand b
  output reg  [31:0] in_c     // operand c
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle at time zero
  initial begin
    op_sel = 3'h7;
    in_a = 32'h0000_0000;
    in_b = 32'h0000_0000;
    in_c = 32'h0000_0000;
  end
  // new set just after a falling edge
  task put(input int op, input int a, input int b, input int c);
    begin
      @(negedge clk);
      op_sel = 3'(op);
      in_a = 32'(a);
      in_b = 32'(b);
      in_c = 32'(c);
    end
  endtask
endmodule

/* core/tlf_consts.vh */
`ifndef TLF_CONSTS_VH
`define TLF_CONSTS_VH
// ****************************************
// operation select codes
// ****************************************
`define TLF_OP_ON_DELAY   3'h0
`define TLF_OP_OFF_DELAY  3'h1
`define TLF_OP_TIMER      3'h2
`define TLF_OP_MIN_PULSE  3'h3
`define TLF_OP_PULSE_TRN  3'h4
`define TLF_OP_WINDOW     3'h5
`define TLF_OP_BIDIR_CNT  3'h6
// ****************************************
// number format and timing
// ****************************************
`define TLF_WIDTH         32
`define TLF_ONE           32'h0000_0064
`define TLF_HYST          32'h0000_0001
`define TLF_SAT_MAX       32'h0031_FF9C
`define TLF_SAT_MIN       32'hFFCE_0000
`define TLF_SECOND_NS     1000000000
`define TLF_CLK_NS        8
`define TLF_TICK_CYCLES   (`TLF_SECOND_NS / `TLF_CLK_NS)
`endif

/* core/tlf_timing_logic.v */
// Notes on behaviour
// - on-delay: rising edge of operand a starts the delay timer
// - on-delay: output true at expiry only if a stayed true throughout
// - delay length from operand b in whole seconds
// - delay modes: nonzero operand c inverts the final output
// - off-delay: falling edge of operand a starts the delay timer
// - off-delay: output false at expiry only if a stayed false
// - timer: output elapsed seconds from zero while a is true
// - timer: hold output while b is true
// - timer: on b release with a true, continue from held value
// - timer: a and b both false clears count; c ignored
// - min pulse: output follows a, stretched to at least b seconds
// - min pulse: operand c true inverts the output
// - pulse train runs only while a true, stops when false
// - pulse train: true for b seconds, false for c seconds
// - window: true when a within b plus or minus c/2
// - window: inside, widen each edge by one least step (0.01)
// - window: zero width means true only when a equals b
// - window: negative width uses magnitude and inverts output
// - counter: rising edge of a adds one, unless b rises in the same cycle
// - counter: rising edge of b subtracts one, unless a rises in the same cycle
// - counter: c true holds the count at zero
// - all numeric results saturate to -32768.00 .. +32767.00
`include "tlf_consts.vh"

module tlf_timing_logic #(
  parameter TICK_CYCLES = `TLF_TICK_CYCLES  // clock cycles per second
) (
  input  wire        MCLK,    // system clock
  input  wire        RST_N,   // async reset, active low
  input  wire [2:0]  OP_SEL,  // operation select
  input  wire [31:0] IN_A,    // operand a, hundredths
  input  wire [31:0] IN_B,    // operand b, hundredths
  input  wire [31:0] IN_C,    // operand c, hundredths
  output reg  [31:0] OUT_VAL  // result, hundredths
);

  // ****************************************
  // helpers
  // ****************************************
  // saturate a wide signed value
  // inputs are 34 bits wide so one step past either limit never wraps
  function [31:0] tlf_sat;
    input signed [33:0] v;
    begin
      if (v > $signed({2'b00, `TLF_SAT_MAX}))
        tlf_sat = `TLF_SAT_MAX;
      else if (v < $signed({2'b11, `TLF_SAT_MIN}))
        tlf_sat = `TLF_SAT_MIN;
      else
        tlf_sat = v[31:0];
    end
  endfunction

  // whole seconds of an operand, negatives as zero
  // fractional seconds are dropped: 2.50 gives a 2 s delay
  function [31:0] tlf_secs;
    input [31:0] v;
    begin
      if (v[31])
        tlf_secs = 32'h0000_0000;
      else
        tlf_secs = v / `TLF_ONE;
    end
  endfunction

  // ****************************************
  // state
  // ****************************************
  reg  [31:0] div_q;       // time base divider
  reg         tick_q;      // one second strobe
  reg         a_prev_q;    // last truth of a
  reg         b_prev_q;    // last truth of b
  reg  [31:0] secs_q;      // seconds elapsed in current phase
  reg         run_q;       // delay or pulse timer running
  reg         lvl_q;       // internal boolean level
  reg         inside_q;    // window inside flag
  reg  [31:0] cnt_q;       // timer or counter value
  reg  [2:0]  op_prev_q;   // last operation code

  // any nonzero operand counts as true; edges are against last cycle
  wire a_t = |IN_A;
  wire b_t = |IN_B;
  wire c_t = |IN_C;
  wire a_rise = a_t & ~a_prev_q;
  wire a_fall = ~a_t & a_prev_q;
  wire b_rise = b_t & ~b_prev_q;
  wire [31:0] b_secs = tlf_secs(IN_B);
  wire [31:0] c_secs = tlf_secs(IN_C);

  // ****************************************
  // time base
  // ****************************************
  // divider strobe
  // free running: a delay may end up to one second early, since
  // the first strobe can follow the start edge by a single cycle
  always @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      div_q  <= 32'h0000_0000;
      tick_q <= 1'b0;
    end else if (div_q >= TICK_CYCLES - 1) begin
      div_q  <= 32'h0000_0000;
      tick_q <= 1'b1;
    end else begin
      div_q  <= div_q + 32'h0000_0001;
      tick_q <= 1'b0;
    end
  end

  // ****************************************
  // window comparison
  // ****************************************
  reg signed [33:0] w_mag;
  reg signed [33:0] w_half;
  reg signed [33:0] w_lo;
  reg signed [33:0] w_hi;
  reg signed [33:0] w_a;
  reg               w_in;
  always @* begin
    w_a    = {{2{IN_A[31]}}, IN_A};
    // magnitude of width
    // take the magnitude first so odd negative widths halve like positive ones
    if (IN_C[31])
      w_mag = 34'h0_0000_0000 - {{2{IN_C[31]}}, IN_C};
    else
      w_mag = {2'b00, IN_C};
    // magnitude is never negative, so a plain shift halves it
    w_half = w_mag >>> 1;
    w_lo   = {{2{IN_B[31]}}, IN_B} - w_half;
    w_hi   = {{2{IN_B[31]}}, IN_B} + w_half;
    // widen while inside
    // hysteresis uses last cycle's inside flag, so a value sitting
    // exactly on an edge cannot make the output chatter
    if (inside_q) begin
      w_lo = w_lo - $signed({2'b00, `TLF_HYST});
      w_hi = w_hi + $signed({2'b00, `TLF_HYST});
    end
    // zero width is equality; range test
    if (IN_C == 32'h0000_0000)
      w_in = (IN_A == IN_B);
    else
      w_in = (w_a >= w_lo) && (w_a <= w_hi);
  end

  // ****************************************
  // operation engine
  // ****************************************
  reg               lvl_d;
  reg               run_d;
  reg        [31:0] secs_d;
  reg        [31:0] cnt_d;
  reg        [31:0] out_d;
  reg signed [33:0] sum;
  // every mode holds its state by default, except secs_d, which counts strobes while run_q; out_d defaults to zero
  always @* begin
    lvl_d  = lvl_q;
    run_d  = run_q;
    secs_d = (run_q && tick_q) ? secs_q + 32'h0000_0001 : secs_q;
    cnt_d  = cnt_q;
    out_d  = 32'h0000_0000;
    sum    = 34'h0_0000_0000;
    case (OP_SEL)
      `TLF_OP_ON_DELAY: begin
        if (a_rise) begin
          run_d  = 1'b1;
          secs_d = 32'h0000_0000;
        end
        if (!a_t) begin
          run_d = 1'b0;
          lvl_d = 1'b0;
        end else if (run_q && !a_rise && secs_d >= b_secs) begin
          run_d = 1'b0;
          lvl_d = 1'b1;
        end
        out_d = ((lvl_d ^ c_t) ? `TLF_ONE : 32'h0000_0000);
      end
      `TLF_OP_OFF_DELAY: begin
        if (a_fall) begin
          run_d  = 1'b1;
          secs_d = 32'h0000_0000;
        end
        if (a_t) begin
          run_d = 1'b0;
          lvl_d = 1'b1;
        end else if (run_q && !a_fall && secs_d >= b_secs) begin
          run_d = 1'b0;
          lvl_d = 1'b0;
        end
        out_d = ((lvl_d ^ c_t) ? `TLF_ONE : 32'h0000_0000);
      end
      `TLF_OP_TIMER: begin
        if (!a_t && !b_t)
          cnt_d = 32'h0000_0000;
        // count seconds while a; hold on b; resume
        else if (a_t && !b_t && tick_q) begin
          sum   = {{2{cnt_q[31]}}, cnt_q} + $signed({2'b00, `TLF_ONE});
          cnt_d = tlf_sat(sum);
        end
        out_d = cnt_d;
      end
      `TLF_OP_MIN_PULSE: begin
        // start pulse on rising edge, stretch
        if (a_rise) begin
          run_d  = 1'b1;
          secs_d = 32'h0000_0000;
        end else if (run_q && secs_d >= b_secs)
          run_d = 1'b0;
        lvl_d = a_t | run_d;
        out_d = ((lvl_d ^ c_t) ? `TLF_ONE : 32'h0000_0000);
      end
      `TLF_OP_PULSE_TRN: begin
        if (!a_t) begin
          run_d  = 1'b0;
          lvl_d  = 1'b0;
          secs_d = 32'h0000_0000;
        end else if (!run_q) begin
          run_d  = 1'b1;
          lvl_d  = 1'b1;
          secs_d = 32'h0000_0000;
        end else if (secs_d >= (lvl_q ? b_secs : c_secs)) begin
          lvl_d  = ~lvl_q;
          secs_d = 32'h0000_0000;
        end
        out_d = (lvl_d ? `TLF_ONE : 32'h0000_0000);
      end
      `TLF_OP_WINDOW: begin
        lvl_d = w_in;
        out_d = ((w_in ^ IN_C[31]) ? `TLF_ONE : 32'h0000_0000);
      end
      `TLF_OP_BIDIR_CNT: begin
        if (c_t)
          cnt_d = 32'h0000_0000;
        else if (a_rise && !b_rise) begin
          sum   = {{2{cnt_q[31]}}, cnt_q} + $signed({2'b00, `TLF_ONE});
          cnt_d = tlf_sat(sum);
        end else if (b_rise && !a_rise) begin
          sum   = {{2{cnt_q[31]}}, cnt_q} - $signed({2'b00, `TLF_ONE});
          cnt_d = tlf_sat(sum);
        end
        out_d = cnt_d;
      end
      default: begin
        out_d = 32'h0000_0000;
      end
    endcase
  end

  // ****************************************
  // registers
  // ****************************************
  // reset clears; mode change restarts
  // a clean restart keeps a stale timer or count of the previous
  // operation from leaking into the new one
  always @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      a_prev_q  <= 1'b0;
      b_prev_q  <= 1'b0;
      secs_q    <= 32'h0000_0000;
      run_q     <= 1'b0;
      lvl_q     <= 1'b0;
      inside_q  <= 1'b0;
      cnt_q     <= 32'h0000_0000;
      op_prev_q <= 3'h0;
      OUT_VAL   <= 32'h0000_0000;
    end else begin
      a_prev_q  <= a_t;
      b_prev_q  <= b_t;
      op_prev_q <= OP_SEL;
      inside_q  <= (OP_SEL == `TLF_OP_WINDOW) ? w_in : 1'b0;
      if (op_prev_q != OP_SEL) begin
        secs_q  <= 32'h0000_0000;
        run_q   <= 1'b0;
        lvl_q   <= 1'b0;
        cnt_q   <= 32'h0000_0000;
        OUT_VAL <= 32'h0000_0000;
      end else begin
        secs_q  <= secs_d;
        run_q   <= run_d;
        lvl_q   <= lvl_d;
        cnt_q   <= cnt_d;
        OUT_VAL <= out_d;
      end
    end
  end

endmodule
